// [src/frls_pkg.sv]
// Constants and types of the frame relay lookup and statistics block
`default_nettype none
package frls_pkg;
  localparam int AW           = 24;
  localparam int SMALL_DLCIS  = 1024;
  localparam int LARGE_DLCIS  = 8192;
  localparam int LUT_ACT_BIT   = 0;
  localparam int IDX_HI        = 15;
  localparam int IDX_LO        = 3;
  localparam int PRIO_ACT_BIT  = 0;
  localparam int PRIO_LAST_BIT = 1;
  localparam int PRIO_MAX      = 256;
  localparam int STAT_WORDS   = 9;
  localparam int CNT_WORDS    = 22;
  localparam int CNT_USED     = 21;
  localparam logic [7:0] CNT_OFF = 8'h2c;
  localparam logic [15:0] MIN_LEN_DATA = 16'h0002;
  localparam logic [15:0] MIN_LEN_ANX  = 16'h0003;
  localparam logic [15:0] MIN_LEN_MGMT = 16'h0004;
  localparam int CI_BAD     = 0;
  localparam int CI_SHORT   = 1;
  localparam int CI_ABORT   = 2;
  localparam int CI_POLL    = 6;
  localparam int CI_ENQ     = 7;
  localparam int CI_UNKNOWN = 10;
  localparam int CI_LONG    = 11;
  typedef logic [12:0]   frls_idx_t;
  typedef logic [AW-1:0] frls_addr_t;
endpackage : frls_pkg
`default_nettype wire

// [src/frls_core_if.sv]
// Links between the core and its counter and priority helpers
`default_nettype none
interface frls_core_if;
  logic        cntPend;
  logic [4:0]  cntSel;
  logic        cntDone;
  logic        prioReq;
  logic [7:0]  prioSlot;
  logic        prioAck;
  logic [15:0] prioWord;
  modport core (input cntPend, cntSel, prioReq, prioSlot,
                output cntDone, prioAck, prioWord);
  modport cnt (output cntPend, cntSel, input cntDone);
  modport sched (output prioReq, prioSlot, input prioAck, prioWord);
endinterface : frls_core_if
`default_nettype wire

// [src/frls_cnt_pend.sv]
// Pending counter events and lowest-index selection
`default_nettype none
module frls_cnt_pend
(
  input  wire logic                          clk,
  input  wire logic                          reset,
  input  wire logic [frls_pkg::CNT_USED-1:0] evt,
  frls_core_if.cnt                           cif
);
  import frls_pkg::*;
  typedef struct packed
  {
    logic [CNT_USED-1:0] pend;
    logic                busy;
    logic [4:0]          sel;
  } frls_cnt_t;
  localparam logic [CNT_USED-1:0] ONE = 1;
  frls_cnt_t  st_r;
  frls_cnt_t  st_nxt;
  logic [4:0] low;

  always_comb
  begin
    low = '0;
    for (int i = CNT_USED - 1; i >= 0; i--)
      if (st_r.pend[i])
        low = 5'(i);
  end

  // Selection is frozen while the core works on it, so a newer
  // lower-index event cannot take the clear meant for the served one
  always_comb
  begin
    st_nxt = st_r;
    if (st_r.busy && cif.cntDone)
    begin
      st_nxt.pend = st_r.pend & ~(ONE << st_r.sel);
      st_nxt.busy = 1'b0;
    end
    else if (!st_r.busy && |st_r.pend)
    begin
      st_nxt.busy = 1'b1;
      st_nxt.sel = low;
    end
    st_nxt.pend = st_nxt.pend | evt;
  end

  assign cif.cntSel = st_r.sel;
  assign cif.cntPend = st_r.busy;

  always_ff @(posedge clk)
  begin
    if (reset)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  chk_set_wins:
  assert property (@(posedge clk) disable iff (reset)
    |evt |=> ((st_r.pend & $past(evt)) == $past(evt)))
  else $error("counter event lost");
endmodule : frls_cnt_pend
`default_nettype wire

// [src/frls_prio_sched.sv]
// Transmit channel walk with priority block diversion
`default_nettype none
module frls_prio_sched
(
  input  wire logic                clk,
  input  wire logic                reset,
  input  wire logic                prioDemand,
  input  wire logic                svcDone,
  input  wire frls_pkg::frls_idx_t ctxLast,
  frls_core_if.sched               cif,
  output logic [12:0]              txCtxIndex,
  output logic                     txInPrio,
  output logic                     txIdxValid
);
  import frls_pkg::*;
  typedef enum logic [1:0] {P_TX = 2'b00, P_FETCH = 2'b01, P_SERVE = 2'b11} frls_pst_t;
  typedef struct packed
  {
    frls_pst_t st;
    logic      dem;
    logic      last;
    logic [7:0] slot;
    frls_idx_t cur;
    frls_idx_t saved;
  } frls_sched_t;
  frls_sched_t st_r;
  frls_sched_t st_nxt;
  frls_idx_t   nextIdx;

  always_comb
  begin
    st_nxt = st_r;
    nextIdx = (st_r.cur == ctxLast) ? '0 : st_r.cur + 13'h1;
    st_nxt.dem = st_r.dem | prioDemand;
    unique case (st_r.st)
      P_TX:
        if (svcDone)
        begin
          if (st_r.dem)
          begin
            st_nxt.saved = nextIdx;
            st_nxt.slot = '0;
            st_nxt.dem = prioDemand;
            st_nxt.st = P_FETCH;
          end
          else
            st_nxt.cur = nextIdx;
        end
      P_FETCH:
        if (cif.prioAck)
        begin
          st_nxt.last = cif.prioWord[PRIO_LAST_BIT] || (st_r.slot == 8'(PRIO_MAX - 1));
          if (cif.prioWord[PRIO_ACT_BIT])
          begin
            st_nxt.cur = cif.prioWord[IDX_HI:IDX_LO];
            st_nxt.st = P_SERVE;
          end
          else if (st_nxt.last)
          begin
            st_nxt.cur = st_r.saved;
            st_nxt.st = P_TX;
          end
          else
            st_nxt.slot = st_r.slot + 8'h1;
        end
      P_SERVE:
        if (svcDone)
        begin
          if (st_r.last)
          begin
            st_nxt.cur = st_r.saved;
            st_nxt.st = P_TX;
          end
          else
          begin
            st_nxt.slot = st_r.slot + 8'h1;
            st_nxt.st = P_FETCH;
          end
        end
      default:
        st_nxt.st = P_TX;
    endcase
  end

  assign cif.prioReq = (st_r.st == P_FETCH);
  assign cif.prioSlot = st_r.slot;
  assign txCtxIndex = st_r.cur;
  assign txInPrio = (st_r.st != P_TX);
  assign txIdxValid = (st_r.st != P_FETCH);

  always_ff @(posedge clk)
  begin
    if (reset)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  chk_prio_resume:
  assert property (@(posedge clk) disable iff (reset)
    (st_r.st == P_SERVE && svcDone && st_r.last) |=> (txCtxIndex == $past(st_r.saved) && !txInPrio))
  else $error("priority walk did not resume");
  chk_prio_skip:
  assert property (@(posedge clk) disable iff (reset)
    (cif.prioAck && !cif.prioWord[PRIO_ACT_BIT] && !cif.prioWord[PRIO_LAST_BIT]
     && st_r.slot != 8'hff)
    |=> (st_r.st == P_FETCH && st_r.slot == $past(st_r.slot) + 8'h1))
  else $error("inactive entry not skipped");
endmodule : frls_prio_sched
`default_nettype wire

// [src/frls_top.sv]
// Receive channel lookup, shared-memory counters, status dump, priority service
`default_nettype none
module frls_top
(
  input  wire logic                 clk,
  input  wire logic                 reset,
  input  wire frls_pkg::frls_addr_t initBlockBase,
  input  wire frls_pkg::frls_addr_t lookupTableBase,
  input  wire frls_pkg::frls_addr_t statusBufferBase,
  input  wire frls_pkg::frls_addr_t priorityBlockBase,
  input  wire logic                 smallTableSelect,
  input  wire logic                 extendedAddressEnable,
  input  wire logic [15:0]          maxFrameLength,
  input  wire logic                 statusRequest,
  input  wire logic                 priorityTransmitDemand,
  input  wire frls_pkg::frls_idx_t  contextLastIndex,
  input  wire logic                 txServiceDone,
  output logic [12:0]               txCtxIndex,
  output logic                      txInPriority,
  output logic                      txIndexValid,
  input  wire logic                 rxFrameEnd,
  output logic                      rxReady,
  input  wire frls_pkg::frls_idx_t  rxDlci,
  input  wire logic [15:0]          rxLength,
  input  wire logic                 rxFcsBad,
  input  wire logic                 rxNonOctet,
  input  wire logic                 rxAborted,
  input  wire logic                 rxMgmt,
  input  wire logic                 rxAnnexAD,
  input  wire logic                 receiveBadFramesSelect,
  input  wire logic                 pollTimerExpire,
  input  wire logic                 statusSeen,
  input  wire logic                 enqTimerExpire,
  input  wire logic                 enquirySeen,
  input  wire logic [13:0]          mgmtEvent,
  output logic                      rxDeliver,
  output logic                      rxDiscard,
  output logic                      frameErrorFlag,
  output logic [12:0]               rxCtxIndex,
  output logic                      statusDone,
  output logic                      memReq,
  output logic                      memWrite,
  output logic [23:0]               memAddr,
  output logic [15:0]               memWdata,
  input  wire logic                 memAck,
  input  wire logic [15:0]          memRdata
);
  import frls_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef enum logic [2:0]
  {
    S_IDLE   = 3'b000,
    S_LOOKUP = 3'b001,
    S_DECIDE = 3'b011,
    S_CNT_RD = 3'b010,
    S_CNT_WR = 3'b110,
    S_STAT   = 3'b111,
    S_PRIO   = 3'b101
  } frls_st_t;

  typedef struct packed
  {
    frls_st_t    st;
    logic        rxBusy;
    frls_idx_t   dlci;
    logic [15:0] len;
    logic        fcsBad, nonOct, abort, mgmt, annex, rbfs;
    logic [15:0] entry;
    logic        statPend;
    logic [3:0]  word;
    logic [4:0]  cntSel;
    logic        deliver, discard, ferr, statDone;
    frls_idx_t   ctxIdx;
    logic        memWr;
    frls_addr_t  memAd;
    logic [15:0] memWd;
  } frls_core_t;

  localparam logic [3:0] STAT_LAST = 4'(STAT_WORDS - 1);

  frls_core_t          st_r;
  frls_core_t          st_nxt;
  logic [CNT_USED-1:0] evt;
  logic                act;
  logic                shortF;
  logic                longF;
  logic                good;
  logic                keep;
  logic [15:0]         minLen;
  frls_core_if         cif ();

  // ----------------------------------------
  // Status buffer helpers
  // ----------------------------------------
  function automatic frls_addr_t statAddr(input logic [3:0] w);
    frls_addr_t b;
    b = statusBufferBase;
    if (!extendedAddressEnable)
      b[23:16] = 8'h00;
    return b + {19'h0, w, 1'b0};
  endfunction : statAddr

  function automatic logic [15:0] statusWord(input logic [3:0] w, input frls_core_t s);
    logic [15:0] v;
    v = '0;
    unique case (w)
      4'h0: v = {14'h0, smallTableSelect, extendedAddressEnable};
      4'h1: v = {3'h0, s.dlci};
      4'h2: v = s.entry;
      4'h3: v = {3'h0, s.ctxIdx};
      4'h4: v = {3'h0, txCtxIndex};
      4'h5: v = {14'h0, txIndexValid, txInPriority};
      4'h6: v = {11'h0, s.cntSel};
      4'h7: v = s.len;
      default: v = {15'h0, s.rxBusy};
    endcase
    return v;
  endfunction : statusWord

  // ----------------------------------------
  // Frame classification
  // ----------------------------------------
  always_comb
  begin
    act = st_r.entry[LUT_ACT_BIT];
    minLen = st_r.mgmt ? (st_r.annex ? MIN_LEN_ANX : MIN_LEN_MGMT) : MIN_LEN_DATA;
    shortF = st_r.len < minLen;
    longF = st_r.len > maxFrameLength;
    good = !st_r.fcsBad && !st_r.nonOct && !st_r.abort && !shortF && !longF;
    keep = act && !shortF && !longF && !st_r.nonOct
           && (good || (st_r.rbfs && (st_r.fcsBad || st_r.abort)));
  end

  // ----------------------------------------
  // Counter events
  // ----------------------------------------
  always_comb
  begin
    evt = '0;
    evt[5:3] = mgmtEvent[2:0];
    evt[CI_POLL] = pollTimerExpire && !statusSeen;
    evt[CI_ENQ] = enqTimerExpire && !enquirySeen;
    evt[9:8] = mgmtEvent[4:3];
    evt[20:12] = mgmtEvent[13:5];
    if (st_r.st == S_DECIDE)
    begin
      evt[CI_BAD] = act && (st_r.fcsBad || st_r.nonOct);
      evt[CI_SHORT] = act && shortF;
      evt[CI_ABORT] = act && st_r.abort;
      evt[CI_UNKNOWN] = !act && good;
      evt[CI_LONG] = act && longF;
    end
  end

  frls_cnt_pend u_cnt
  (
    .clk   (clk),
    .reset (reset),
    .evt   (evt),
    .cif   (cif)
  );

  frls_prio_sched u_sched
  (
    .clk        (clk),
    .reset      (reset),
    .prioDemand (priorityTransmitDemand),
    .svcDone    (txServiceDone),
    .ctxLast    (contextLastIndex),
    .cif        (cif),
    .txCtxIndex (txCtxIndex),
    .txInPrio   (txInPriority),
    .txIdxValid (txIndexValid)
  );

  // ----------------------------------------
  // Main sequencer
  // ----------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.deliver = 1'b0;
    st_nxt.discard = 1'b0;
    st_nxt.statDone = 1'b0;
    if (statusRequest)
      st_nxt.statPend = 1'b1;
    if (rxFrameEnd && !st_r.rxBusy)
    begin
      st_nxt.rxBusy = 1'b1;
      st_nxt.dlci = rxDlci;
      st_nxt.len = rxLength;
      st_nxt.fcsBad = rxFcsBad;
      st_nxt.nonOct = rxNonOctet;
      st_nxt.abort = rxAborted;
      st_nxt.mgmt = rxMgmt;
      st_nxt.annex = rxAnnexAD;
      st_nxt.rbfs = receiveBadFramesSelect;
    end
    unique case (st_r.st)
      S_IDLE:
        if (st_r.statPend)
        begin
          st_nxt.statPend = statusRequest;
          st_nxt.word = '0;
          st_nxt.memWr = 1'b1;
          st_nxt.memAd = statAddr(4'h0);
          st_nxt.memWd = statusWord(4'h0, st_r);
          st_nxt.st = S_STAT;
        end
        else if (st_r.rxBusy)
        begin
          st_nxt.memWr = 1'b0;
          st_nxt.memAd = lookupTableBase + {10'h0, st_r.dlci, 1'b0};
          if (smallTableSelect && st_r.dlci >= 13'(SMALL_DLCIS))
          begin
            st_nxt.entry = '0;
            st_nxt.st = S_DECIDE;
          end
          else
            st_nxt.st = S_LOOKUP;
        end
        else if (cif.prioReq)
        begin
          st_nxt.memWr = 1'b0;
          st_nxt.memAd = priorityBlockBase + {15'h0, cif.prioSlot, 1'b0};
          st_nxt.st = S_PRIO;
        end
        else if (cif.cntPend)
        begin
          st_nxt.memWr = 1'b0;
          st_nxt.cntSel = cif.cntSel;
          st_nxt.memAd = initBlockBase + {16'h0, CNT_OFF} + {18'h0, cif.cntSel, 1'b0};
          st_nxt.st = S_CNT_RD;
        end
      S_LOOKUP:
        if (memAck)
        begin
          st_nxt.entry = memRdata;
          st_nxt.st = S_DECIDE;
        end
      S_DECIDE:
      begin
        st_nxt.deliver = keep;
        st_nxt.discard = !keep;
        st_nxt.ferr = keep && (st_r.fcsBad || st_r.abort);
        st_nxt.ctxIdx = st_r.entry[IDX_HI:IDX_LO];
        st_nxt.rxBusy = 1'b0;
        st_nxt.st = S_IDLE;
      end
      S_CNT_RD:
        if (memAck)
        begin
          st_nxt.memWr = 1'b1;
          st_nxt.memWd = memRdata + 16'h1;
          st_nxt.st = S_CNT_WR;
        end
      S_CNT_WR:
        if (memAck)
        begin
          st_nxt.memWr = 1'b0;
          st_nxt.st = S_IDLE;
        end
      S_STAT:
        if (memAck)
        begin
          if (st_r.word == STAT_LAST)
          begin
            st_nxt.statDone = 1'b1;
            st_nxt.memWr = 1'b0;
            st_nxt.st = S_IDLE;
          end
          else
          begin
            st_nxt.word = st_r.word + 4'h1;
            st_nxt.memAd = statAddr(st_r.word + 4'h1);
            st_nxt.memWd = statusWord(st_r.word + 4'h1, st_r);
          end
        end
      S_PRIO:
        if (memAck)
          st_nxt.st = S_IDLE;
      default:
        st_nxt.st = S_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign cif.cntDone = (st_r.st == S_CNT_WR) && memAck;
  assign cif.prioAck = (st_r.st == S_PRIO) && memAck;
  assign cif.prioWord = memRdata;
  assign memReq = (st_r.st != S_IDLE) && (st_r.st != S_DECIDE);
  assign memWrite = st_r.memWr;
  assign memAddr = st_r.memAd;
  assign memWdata = st_r.memWd;
  assign rxReady = !st_r.rxBusy;
  assign rxDeliver = st_r.deliver;
  assign rxDiscard = st_r.discard;
  assign frameErrorFlag = st_r.ferr;
  assign rxCtxIndex = st_r.ctxIdx;
  assign statusDone = st_r.statDone;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_small_range:
  assert property (@(posedge clk) disable iff (reset)
    (st_r.st == S_LOOKUP && smallTableSelect) |-> st_r.dlci < 13'(SMALL_DLCIS))
  else $error("small table read beyond range");
  chk_lookup_addr:
  assert property (@(posedge clk) disable iff (reset)
    (st_r.st == S_LOOKUP) |-> (!memWrite && memAddr == lookupTableBase + {10'h0, st_r.dlci, 1'b0}))
  else $error("lookup address wrong");
  chk_inactive_drop:
  assert property (@(posedge clk) disable iff (reset)
    rxDeliver |-> (st_r.entry[LUT_ACT_BIT] && !rxDiscard))
  else $error("inactive DLCI delivered");
  chk_ctx_index:
  assert property (@(posedge clk) disable iff (reset)
    (rxDeliver || rxDiscard) |-> rxCtxIndex == st_r.entry[IDX_HI:IDX_LO])
  else $error("context index wrong");
  chk_status_len:
  assert property (@(posedge clk) disable iff (reset)
    (st_r.st == S_STAT && memAck && st_r.word == 4'h8) |=> (statusDone && st_r.st == S_IDLE))
  else $error("status dump length wrong");
  chk_cnt_incr:
  assert property (@(posedge clk) disable iff (reset)
    (st_r.st == S_CNT_RD && memAck)
    |=> (memWrite && memWdata == $past(memRdata) + 16'h1 && memAddr == $past(memAddr)))
  else $error("counter not incremented");
  chk_bad_gate:
  assert property (@(posedge clk) disable iff (reset)
    (st_r.st == S_DECIDE && !st_r.rbfs && !good) |=> (rxDiscard && !rxDeliver))
  else $error("bad frame delivered");
  chk_flag_cause:
  assert property (@(posedge clk) disable iff (reset)
    (rxDeliver || rxDiscard)
    |-> (frameErrorFlag == (rxDeliver && st_r.rbfs && (st_r.fcsBad || st_r.abort))))
  else $error("frame error flag without cause");
  chk_unknown_cnt:
  assert property (@(posedge clk) disable iff (reset)
    (st_r.st == S_DECIDE && !st_r.entry[LUT_ACT_BIT] && good) |-> evt[CI_UNKNOWN] && !evt[CI_BAD])
  else $error("unknown DLCI not counted");
endmodule : frls_top
`default_nettype wire

// [test/frls_mem_model.sv]
// Shared memory model answering the block's memory port
`default_nettype none
module frls_mem_model
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        memReq,
  input  wire logic        memWrite,
  input  wire logic [23:0] memAddr,
  input  wire logic [15:0] memWdata,
  output logic             memAck,
  output logic [15:0]      memRdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [int];
  logic [1:0]  waitCnt;
  logic        slow;
  initial
  begin
    memAck   = 1'b0;
    memRdata = 16'h0000;
  end
  // ----------------------------------------
  // Answers alternate prompt and slow
  // ----------------------------------------
  always @(posedge clk)
  begin
    memAck <= 1'b0;
    if (reset)
    begin
      waitCnt <= 2'h0;
      slow    <= 1'b0;
    end
    else if (memReq && !memAck && waitCnt != (slow ? 2'h3 : 2'h0))
      waitCnt <= waitCnt + 2'h1;
    else if (memReq && !memAck)
    begin
      memAck  <= 1'b1;
      waitCnt <= 2'h0;
      slow    <= ~slow;
      if (memWrite)
        mem[int'(memAddr)] = memWdata;
      else
        memRdata <= mem.exists(int'(memAddr)) ? mem[int'(memAddr)] : 16'h0000;
    end
    else
      memRdata <= ~memRdata;
  end
endmodule : frls_mem_model
`default_nettype wire

// [test/testbench.sv]
// Directed bench for lookup, counters, status dump and priority service
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CB = 'h1000;
  localparam int LB = 'h2000;
  localparam int SB = 'h3000;
  localparam int PB = 'h4000;
  logic        clk, reset, smallTableSelect, extendedAddressEnable, statusRequest;
  logic        priorityTransmitDemand, txServiceDone, rxFrameEnd, rxFcsBad, rxNonOctet;
  logic        rxAborted, rxMgmt, rxAnnexAD, receiveBadFramesSelect, pollTimerExpire;
  logic        statusSeen, enqTimerExpire, enquirySeen, txInPriority, txIndexValid;
  logic        rxReady, rxDeliver, rxDiscard, frameErrorFlag, statusDone;
  logic        memReq, memWrite, memAck;
  logic [23:0] initBlockBase, lookupTableBase, statusBufferBase, priorityBlockBase, memAddr;
  logic [15:0] maxFrameLength, rxLength, memWdata, memRdata;
  logic [12:0] contextLastIndex, rxDlci, txCtxIndex, rxCtxIndex;
  logic [13:0] mgmtEvent;
  logic [15:0] expc [22];
  int          mismatches, n_compared, statusWrites, i, b;

  frls_top uut (.clk, .reset, .initBlockBase, .lookupTableBase, .statusBufferBase,
    .priorityBlockBase, .smallTableSelect, .extendedAddressEnable, .maxFrameLength,
    .statusRequest, .priorityTransmitDemand, .contextLastIndex, .txServiceDone,
    .txCtxIndex, .txInPriority, .txIndexValid, .rxFrameEnd, .rxReady, .rxDlci, .rxLength,
    .rxFcsBad, .rxNonOctet, .rxAborted, .rxMgmt, .rxAnnexAD, .receiveBadFramesSelect,
    .pollTimerExpire, .statusSeen, .enqTimerExpire, .enquirySeen, .mgmtEvent, .rxDeliver,
    .rxDiscard, .frameErrorFlag, .rxCtxIndex, .statusDone, .memReq, .memWrite, .memAddr,
    .memWdata, .memAck, .memRdata);
  frls_mem_model mm (.clk, .reset, .memReq, .memWrite, .memAddr, .memWdata, .memAck,
    .memRdata);

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Counts status words landing in the buffer
  always @(posedge clk)
    if (memReq && memAck && memWrite && memAddr >= 24'(SB) && memAddr < 24'(SB + 18))
      statusWrites++;

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : conclude
  task automatic timeout;
    mismatches++;
    $display("Error at %0t: wait ran out", $time);
    conclude();
  endtask : timeout
  function automatic logic [15:0] memRd(input int a);
    return mm.mem.exists(a) ? mm.mem[a] : 16'h0000;
  endfunction : memRd
  // Flags are {fcsBad, nonOctet, aborted, mgmt, annex, badFramesSelect}
  task automatic frame(input logic [12:0] d, input logic [15:0] len, input logic [5:0] f,
                       input logic expDel, input logic expFlag, input logic [12:0] expIdx);
    int k;
    for (k = 0; k < 100 && rxReady !== 1'b1; k++) @(negedge clk);
    if (k >= 100)
      timeout();
    rxDlci <= d;
    rxLength <= len;
    {rxFcsBad, rxNonOctet, rxAborted, rxMgmt, rxAnnexAD, receiveBadFramesSelect} <= f;
    rxFrameEnd <= 1'b1;
    @(negedge clk);
    rxFrameEnd <= 1'b0;
    k = 0;
    do
    begin
      @(posedge clk);
      #1;
      k++;
    end
    while (rxDeliver !== 1'b1 && rxDiscard !== 1'b1 && k < 100);
    if (k >= 100)
      timeout();
    check(rxDeliver, expDel);
    check(rxDiscard, !expDel);
    if (expDel)
    begin
      check(rxCtxIndex, expIdx);
      check(frameErrorFlag, expFlag);
    end
    @(negedge clk);
  endtask : frame
  task automatic cnt(input int ci, input logic [15:0] inc);
    int k;
    expc[ci] = expc[ci] + inc;
    for (k = 0; k < 300 && memRd(CB + 44 + 2 * ci) !== expc[ci]; k++) @(negedge clk);
    if (k >= 300)
      timeout();
    check(memRd(CB + 44 + 2 * ci), expc[ci]);
  endtask : cnt
  task automatic svc(input logic [12:0] e, input logic p);
    int k;
    txServiceDone <= 1'b1;
    @(negedge clk);
    txServiceDone <= 1'b0;
    repeat (2) @(negedge clk);
    for (k = 0; k < 100 && txIndexValid !== 1'b1; k++) @(negedge clk);
    if (k >= 100)
      timeout();
    check(txCtxIndex, e);
    check(txInPriority, p);
  endtask : svc

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    {reset, smallTableSelect, extendedAddressEnable, statusRequest} = 4'hf;
    {priorityTransmitDemand, txServiceDone, rxFrameEnd, rxFcsBad, rxNonOctet} = 5'h0;
    {rxAborted, rxMgmt, rxAnnexAD, receiveBadFramesSelect, pollTimerExpire} = 5'h0;
    {statusSeen, enqTimerExpire, enquirySeen} = 3'h0;
    {smallTableSelect, extendedAddressEnable, statusRequest} = 3'h0;
    {initBlockBase, lookupTableBase} = {24'(CB), 24'(LB)};
    {statusBufferBase, priorityBlockBase} = {24'(SB), 24'(PB)};
    {maxFrameLength, rxLength, rxDlci, contextLastIndex, mgmtEvent} = {16'd100, 16'h0,
      13'h0, 13'd9, 14'h0};
    {mismatches, n_compared, statusWrites} = '0;
    foreach (expc[k]) expc[k] = 16'h0000;
    mm.mem[CB + 68] = 16'hffff;
    expc[12] = 16'hffff;
    mm.mem[LB + 10] = {13'd300, 3'b001};
    mm.mem[LB + 12] = {13'd77, 3'b000};
    mm.mem[LB + 3000] = {13'd9, 3'b001};
    mm.mem[PB + 0] = 16'h0000;
    mm.mem[PB + 2] = {13'd5, 3'b001};
    mm.mem[PB + 4] = {13'd7, 3'b011};
    repeat (10) @(negedge clk);
    reset <= 1'b0;
    frame(13'd5, 16'd20, 6'b000000, 1'b1, 1'b0, 13'd300);
    frame(13'd6, 16'd20, 6'b000000, 1'b0, 1'b0, 13'd0);
    cnt(10, 16'h1);
    frame(13'd5, 16'd20, 6'b100000, 1'b0, 1'b0, 13'd0);
    cnt(0, 16'h1);
    frame(13'd5, 16'd20, 6'b100001, 1'b1, 1'b1, 13'd300);
    cnt(0, 16'h1);
    frame(13'd5, 16'd20, 6'b001001, 1'b1, 1'b1, 13'd300);
    cnt(2, 16'h1);
    frame(13'd5, 16'd20, 6'b010001, 1'b0, 1'b0, 13'd0);
    cnt(0, 16'h1);
    $display("test receive errors done");
    frame(13'd5, 16'd1, 6'b000000, 1'b0, 1'b0, 13'd0);
    cnt(1, 16'h1);
    frame(13'd5, 16'd2, 6'b000110, 1'b0, 1'b0, 13'd0);
    cnt(1, 16'h1);
    frame(13'd5, 16'd3, 6'b000100, 1'b0, 1'b0, 13'd0);
    cnt(1, 16'h1);
    frame(13'd5, 16'd2, 6'b000000, 1'b1, 1'b0, 13'd300);
    frame(13'd5, 16'd101, 6'b000000, 1'b0, 1'b0, 13'd0);
    cnt(11, 16'h1);
    frame(13'd5, 16'd100, 6'b000000, 1'b1, 1'b0, 13'd300);
    frame(13'd1500, 16'd20, 6'b000000, 1'b1, 1'b0, 13'd9);
    smallTableSelect <= 1'b1;
    frame(13'd1500, 16'd20, 6'b000000, 1'b0, 1'b0, 13'd0);
    cnt(10, 16'h1);
    $display("test lengths and table size done");
    for (b = 0; b < 4; b++)
    begin
      {pollTimerExpire, statusSeen, enqTimerExpire, enquirySeen} <= 4'(16'h32c8 >> (4 * b));
      @(negedge clk);
      {pollTimerExpire, enqTimerExpire} <= 2'b00;
      repeat (20) @(negedge clk);
      cnt(b < 2 ? 6 : 7, 16'(b % 2 == 0));
    end
    for (b = 0; b < 14; b++)
    begin
      mgmtEvent <= 14'h1 << b;
      @(negedge clk);
      mgmtEvent <= 14'h0;
      cnt(b < 3 ? 3 + b : (b < 5 ? 5 + b : 7 + b), 16'h1);
    end
    $display("test counters done");
    statusWrites = 0;
    statusRequest <= 1'b1;
    @(negedge clk);
    statusRequest <= 1'b0;
    for (i = 0; i < 400 && statusDone !== 1'b1; i++) @(negedge clk);
    if (i >= 400)
      timeout();
    check(24'(statusWrites), 24'd9);
    check(memRd(SB + 2), 16'd1500);
    priorityTransmitDemand <= 1'b1;
    @(negedge clk);
    priorityTransmitDemand <= 1'b0;
    svc(13'd5, 1'b1);
    svc(13'd7, 1'b1);
    svc(13'd1, 1'b0);
    svc(13'd2, 1'b0);
    $display("test status and priority done");
    reset <= 1'b1;
    repeat (2) @(negedge clk);
    reset <= 1'b0;
    repeat (20) @(negedge clk);
    check(memRd(CB + 44), expc[0]);
    conclude();
  end
endmodule : testbench
`default_nettype wire
